// ### logic/tmap_pkg.sv
// Shared constants and types for the tag memory access protection block
package tmap_pkg;

	// Serial slave operate-codes
	localparam logic [7:0] SLAVE_WORD_WRITE_CMD = 8'h02;
	localparam logic [7:0] SLAVE_WORD_READ_CMD = 8'h03;
	localparam logic [7:0] SLAVE_STATUS_READ_CMD = 8'h05;

	// Air-interface write command code
	localparam logic [7:0] AIR_WRITE_CMD = 8'hc3;

	// Memory bank codes
	localparam logic [1:0] BANK_RESERVED = 2'h0;
	localparam logic [1:0] BANK_EPC = 2'h1;
	localparam logic [1:0] BANK_TID = 2'h2;
	localparam logic [1:0] BANK_USER = 2'h3;

	// Word addresses inside the reserved and user banks
	localparam logic [13:0] KILL_PW_FIRST = 14'h0000;
	localparam logic [13:0] KILL_PW_LAST = 14'h0001;
	localparam logic [13:0] ACCESS_PW_FIRST = 14'h0002;
	localparam logic [13:0] ACCESS_PW_LAST = 14'h0003;
	localparam logic [13:0] AREA_PW_FIRST = 14'h0020;
	localparam logic [13:0] AREA_PW_LAST = 14'h002f;
	localparam logic [13:0] AREA_AUTH_FIRST = 14'h0030;
	localparam logic [13:0] AREA_AUTH_LAST = 14'h003f;
	localparam logic [13:0] USER_LAST_WORD = 14'h0eff;

	// User area geometry: seven areas of 200h words and a last of 100h up to word 0eff
	localparam int AREA_SHIFT = 9;
	localparam int AREA_COUNT = 8;
	localparam int AREA_PW_WORDS = 16;

	// Lock payload field positions (each pair is {lock, permalock})
	localparam int LOCK_KILL_POS = 8;
	localparam int LOCK_ACCESS_POS = 6;
	localparam int LOCK_EPC_POS = 4;
	localparam int LOCK_TID_POS = 2;
	localparam int LOCK_USER_POS = 0;

	// Error status word layout and reset value
	localparam int ERR_LOCKED_BIT = 1;
	localparam int ERR_KILLED_BIT = 0;
	localparam logic [15:0] ERR_STATUS_RESET = 16'h0000;
	localparam logic [15:0] PW_RESET = 16'h0000;

	typedef enum logic [1:0] {
		ST_SECURED = 2'b01,
		ST_AREA_UNLOCKED = 2'b10
	} tmap_state_type;

endpackage : tmap_pkg

// ### logic/tmap_prot_check.sv
// Combinational protection decoder for one word access
`timescale 1ns/1ps
`default_nettype none
module tmap_prot_check (
	input wire logic [1:0] bank, // Target memory bank
	input wire logic [13:0] addr, // Target word address
	input wire logic is_write, // High for a write, low for a read
	input wire logic from_air, // High for air access, low for serial
	input wire logic secured, // Protocol engine is in Secured state
	input wire logic killed, // Tag is killed
	input wire logic access_pw_set, // Access password is nonzero
	input wire logic [9:0] lock_payload, // Lock payload bits [9:0]
	input wire logic [7:0] perm_mask, // Permalock mask, bit 0 = area 0
	input wire logic [7:0] area_pw_set, // Area password is nonzero
	input wire logic area_open, // An area is authenticated
	input wire logic [2:0] open_area, // Index of the authenticated area
	output logic deny_killed, // Access refused: tag killed
	output logic deny_locked // Access refused: lock or password
);

	// A locked pair blocks writes unless the tag is secured; a permalocked
	// lock blocks them always. Serial access never counts as secured.
	function automatic logic pair_blocks(input logic [1:0] pair,
		input logic sec_ok);
		pair_blocks = pair[1] & (pair[0] | ~sec_ok);
	endfunction : pair_blocks

	logic [2:0] area;
	logic sec_ok;
	logic pw_guard;
	logic in_range;

	assign area = addr[tmap_pkg::AREA_SHIFT +: 3];
	assign sec_ok = from_air & secured;
	assign in_range = addr <= tmap_pkg::USER_LAST_WORD;
	assign pw_guard = area_pw_set[area] & ~(area_open && open_area == area);

	always_comb begin
		deny_killed = killed;
		deny_locked = 1'b0;
		if (!from_air && access_pw_set) begin
			deny_locked = 1'b1;
		end
		case (bank)
			tmap_pkg::BANK_RESERVED: begin
				if (!from_air) begin
					deny_locked = 1'b1;
				end else if (is_write) begin
					if (addr <= tmap_pkg::KILL_PW_LAST) begin
						if (pair_blocks(lock_payload[tmap_pkg::LOCK_KILL_POS +: 2],
							sec_ok)) begin
							deny_locked = 1'b1;
						end
					end else if ((addr >= tmap_pkg::ACCESS_PW_FIRST &&
						addr <= tmap_pkg::ACCESS_PW_LAST) ||
						(addr >= tmap_pkg::AREA_PW_FIRST &&
						addr <= tmap_pkg::AREA_PW_LAST)) begin
						if (pair_blocks(lock_payload[tmap_pkg::LOCK_ACCESS_POS +: 2],
							sec_ok)) begin
							deny_locked = 1'b1;
						end
					end
				end
			end
			tmap_pkg::BANK_EPC: begin
				if (is_write && (!from_air ||
					pair_blocks(lock_payload[tmap_pkg::LOCK_EPC_POS +: 2],
					sec_ok))) begin
					deny_locked = 1'b1;
				end
			end
			tmap_pkg::BANK_TID: begin
				if (is_write && (!from_air ||
					pair_blocks(lock_payload[tmap_pkg::LOCK_TID_POS +: 2],
					sec_ok))) begin
					deny_locked = 1'b1;
				end
			end
			default: begin
				if (!in_range) begin
					deny_locked = 1'b1;
				end
				if (pw_guard) begin
					deny_locked = 1'b1;
				end
				if (is_write &&
					(pair_blocks(lock_payload[tmap_pkg::LOCK_USER_POS +: 2],
					sec_ok) || perm_mask[area])) begin
					deny_locked = 1'b1;
				end
			end
		endcase
	end

endmodule : tmap_prot_check
`default_nettype wire

// ### logic/tmap_top.sv
// Access protection, area passwords and serial error status for the tag
`timescale 1ns/1ps
`default_nettype none
module tmap_top (
	input wire logic clk_sys, // System clock, 100 MHz
	input wire logic srst, // Synchronous reset, power loss
	input wire logic killed, // Tag is killed
	input wire logic secured, // Protocol engine is in Secured state
	input wire logic access_pw_set, // Access password is nonzero
	input wire logic [9:0] lock_payload, // Stored lock payload bits
	input wire logic [15:0] perm_mask, // Permalock mask, bits 15:8 used
	input wire logic slv_req, // Serial command pulse
	input wire logic [7:0] slv_op, // Serial operate-code
	input wire logic [1:0] slv_bank, // Serial target bank
	input wire logic [13:0] slv_addr, // Serial target word address
	input wire logic [15:0] slv_mem_rdata, // Memory word for serial read
	input wire logic slv_done, // Status read completed its 16 clocks
	input wire logic air_req, // Air write command pulse
	input wire logic [7:0] air_cmd, // Air command code
	input wire logic [1:0] air_bank, // Air target bank
	input wire logic [13:0] air_addr, // Air target word address
	input wire logic [15:0] air_data, // Air data word, RN16-covered
	input wire logic [15:0] air_rn16, // Tag RN16 for uncovering data
	output logic [15:0] slv_rdata, // Word shifted out on serial data
	output logic slv_wr_en, // Serial write allowed to memory
	output logic [15:0] err_status, // Error status word
	output logic air_wr_en, // Air write allowed to memory
	output logic air_reply, // Send reply to the reader
	output logic area_unlocked, // In area-unlocked state
	output logic [2:0] unlocked_area // Index of the opened area
);

	logic [15:0] area_pw_reg [0:tmap_pkg::AREA_PW_WORDS-1];
	tmap_pkg::tmap_state_type state_reg;
	logic [2:0] open_area_reg;
	logic half_pending_reg;
	logic [2:0] half_area_reg;
	logic [15:0] half_word_reg;
	logic [7:0] area_pw_nz;
	logic [7:0] area_mask;
	logic slv_kill;
	logic slv_lock;
	logic air_kill;
	logic air_lock;
	logic slv_is_write;
	logic slv_is_read;
	logic slv_is_status;
	logic air_write;
	logic air_pw_set;
	logic air_auth;
	logic [15:0] plain_word;
	logic [31:0] full_pw;
	logic [31:0] stored_pw;
	logic [2:0] auth_area;
	logic base_state;
	logic area_open;
	logic half_match;

	// Permalock mask bit 15 covers area 0, bit 8 area 7
	genvar gi;
	generate
		for (gi = 0; gi < tmap_pkg::AREA_COUNT; gi = gi + 1) begin : g_area
			assign area_mask[gi] = perm_mask[15 - gi];
			assign area_pw_nz[gi] = (area_pw_reg[2 * gi] != 16'h0000) ||
				(area_pw_reg[2 * gi + 1] != 16'h0000);
		end
	endgenerate

	// Decodes shared by the serial opcode and password window paths
	function automatic logic slv_cmd(input logic req, input logic [7:0] op,
		input logic [7:0] code);
		slv_cmd = req && op == code;
	endfunction : slv_cmd

	function automatic logic in_window(input logic [13:0] a,
		input logic [13:0] first, input logic [13:0] last);
		in_window = a >= first && a <= last;
	endfunction : in_window

	assign slv_is_write = slv_cmd(slv_req, slv_op,
		tmap_pkg::SLAVE_WORD_WRITE_CMD);
	assign slv_is_read = slv_cmd(slv_req, slv_op,
		tmap_pkg::SLAVE_WORD_READ_CMD);
	assign slv_is_status = slv_cmd(slv_req, slv_op,
		tmap_pkg::SLAVE_STATUS_READ_CMD);
	assign base_state = state_reg == tmap_pkg::ST_SECURED;
	// Both checkers must judge against one view of the open area
	assign area_open = state_reg == tmap_pkg::ST_AREA_UNLOCKED;
	// A second half only counts against the area its first half named
	assign half_match = half_pending_reg && half_area_reg == auth_area;

	assign air_write = air_req && air_cmd == tmap_pkg::AIR_WRITE_CMD;
	assign air_pw_set = air_write && air_bank == tmap_pkg::BANK_RESERVED &&
		in_window(air_addr, tmap_pkg::AREA_PW_FIRST,
		tmap_pkg::AREA_PW_LAST);
	assign air_auth = air_write && air_bank == tmap_pkg::BANK_RESERVED &&
		in_window(air_addr, tmap_pkg::AREA_AUTH_FIRST,
		tmap_pkg::AREA_AUTH_LAST);
	assign plain_word = air_data ^ air_rn16;
	assign auth_area = air_addr[3:1];
	assign full_pw = {half_word_reg, plain_word};
	assign stored_pw = {area_pw_reg[{auth_area, 1'b0}],
		area_pw_reg[{auth_area, 1'b1}]};

	tmap_prot_check u_slv_check (
		.bank(slv_bank),
		.addr(slv_addr),
		.is_write(slv_is_write),
		.from_air(1'b0),
		.secured(secured),
		.killed(killed),
		.access_pw_set(access_pw_set),
		.lock_payload(lock_payload),
		.perm_mask(area_mask),
		.area_pw_set(area_pw_nz),
		.area_open(area_open),
		.open_area(open_area_reg),
		.deny_killed(slv_kill),
		.deny_locked(slv_lock)
	);

	tmap_prot_check u_air_check (
		.bank(air_bank),
		.addr(air_addr),
		.is_write(1'b1),
		.from_air(1'b1),
		.secured(secured),
		.killed(killed),
		.access_pw_set(access_pw_set),
		.lock_payload(lock_payload),
		.perm_mask(area_mask),
		.area_pw_set(area_pw_nz),
		.area_open(area_open),
		.open_area(open_area_reg),
		.deny_killed(air_kill),
		.deny_locked(air_lock)
	);

	// Error status: only hardware events set bits; no write path exists,
	// so a host write to this word has nothing to act on.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			err_status <= tmap_pkg::ERR_STATUS_RESET;
		end else begin
			// Set wins over the clear in the same cycle
			if (slv_done) begin
				err_status <= tmap_pkg::ERR_STATUS_RESET;
			end
			if ((slv_is_read || slv_is_write) && slv_kill) begin
				err_status[tmap_pkg::ERR_KILLED_BIT] <= 1'b1;
			end
			if ((slv_is_read || slv_is_write) && slv_lock) begin
				err_status[tmap_pkg::ERR_LOCKED_BIT] <= 1'b1;
			end
		end
	end

	// Serial read data and write strobe
	// A status read returns the word as it stood before this edge's update
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			slv_rdata <= 16'h0000;
		end else if (slv_is_status) begin
			slv_rdata <= err_status;
		end else if (slv_is_read) begin
			if (slv_kill || slv_lock) begin
				slv_rdata <= 16'h0000;
			end else begin
				slv_rdata <= slv_mem_rdata;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			slv_wr_en <= 1'b0;
		end else begin
			slv_wr_en <= slv_is_write && !slv_kill && !slv_lock;
		end
	end

	// Ordinary air writes outside the password windows
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			air_wr_en <= 1'b0;
		end else begin
			air_wr_en <= air_write && !air_pw_set && !air_auth &&
				!air_kill && !air_lock;
		end
	end

	// Area password store, cleared only by power loss
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			for (int i = 0; i < tmap_pkg::AREA_PW_WORDS; i++) begin
				area_pw_reg[i] <= tmap_pkg::PW_RESET;
			end
		end else if (air_pw_set && secured && base_state &&
			!air_kill && !air_lock) begin
			area_pw_reg[air_addr[3:0]] <= plain_word;
		end
	end

	// First half of an authentication is held until its partner arrives
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			half_pending_reg <= 1'b0;
			half_area_reg <= 3'h0;
			half_word_reg <= 16'h0000;
		end else if (air_auth && secured && !air_kill) begin
			if (!air_addr[0]) begin
				half_pending_reg <= 1'b1;
				half_area_reg <= auth_area;
				half_word_reg <= plain_word;
			end else begin
				// An odd half consumes the pending half, match or not
				half_pending_reg <= 1'b0;
			end
		end else if (!secured) begin
			half_pending_reg <= 1'b0;
		end
	end

	// Area state: a zero password always returns to Secured; a nonzero
	// one is only honoured from Secured, so areas open one at a time.
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_reg <= tmap_pkg::ST_SECURED;
			open_area_reg <= 3'h0;
		end else if (!secured) begin
			state_reg <= tmap_pkg::ST_SECURED;
		end else if (air_auth && air_addr[0] && half_match &&
			!air_kill) begin
			case (state_reg)
				tmap_pkg::ST_SECURED: begin
					if (full_pw != 32'h0000_0000 &&
						full_pw == stored_pw) begin
						state_reg <= tmap_pkg::ST_AREA_UNLOCKED;
						open_area_reg <= auth_area;
					end
				end
				tmap_pkg::ST_AREA_UNLOCKED: begin
					if (full_pw == 32'h0000_0000) begin
						state_reg <= tmap_pkg::ST_SECURED;
					end
				end
				default: begin
					// Illegal state codes fall back to the safe state
					state_reg <= tmap_pkg::ST_SECURED;
				end
			endcase
		end
	end

	// Reply only to executed password operations; a failed check is silent
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			air_reply <= 1'b0;
		end else if (!secured || air_kill) begin
			air_reply <= 1'b0;
		end else if (air_pw_set) begin
			air_reply <= base_state && !air_lock;
		end else if (air_auth && !air_addr[0]) begin
			air_reply <= 1'b1;
		end else if (air_auth && half_match) begin
			air_reply <= (full_pw == 32'h0000_0000) ||
				(base_state && full_pw == stored_pw);
		end else begin
			air_reply <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			area_unlocked <= 1'b0;
			unlocked_area <= 3'h0;
		end else begin
			area_unlocked <= area_open;
			unlocked_area <= open_area_reg;
		end
	end

endmodule : tmap_top
`default_nettype wire

// ### verif/tmap_mem_model.sv
// Memory array model feeding words to serial reads
`timescale 1ns/1ps
`default_nettype none
module tmap_mem_model (
	input wire logic [1:0] bank, // Addressed bank
	input wire logic [13:0] addr, // Addressed word
	output logic [15:0] rdata // Stored word
);
	// Each word encodes its own address so a stale or wrong word shows
	assign rdata = {bank, addr} ^ 16'ha5a5;
endmodule : tmap_mem_model
`default_nettype wire

// ### verif/tmap_top_monitor.sv
// Port checker for the tag memory access protection block
`timescale 1ns/1ps
`default_nettype none
module tmap_top_monitor (
	input wire logic clk_sys, // Clock
	input wire logic srst, // Reset
	input wire logic killed, // Tag killed
	input wire logic secured, // Secured state
	input wire logic access_pw_set, // Access password set
	input wire logic [15:0] perm_mask, // Permalock mask
	input wire logic slv_req, // Serial command
	input wire logic [7:0] slv_op, // Serial opcode
	input wire logic [1:0] slv_bank, // Serial bank
	input wire logic [13:0] slv_addr, // Serial address
	input wire logic [15:0] slv_mem_rdata, // Memory word
	input wire logic slv_done, // Status read done
	input wire logic air_req, // Air command
	input wire logic [7:0] air_cmd, // Air code
	input wire logic [1:0] air_bank, // Air bank
	input wire logic [13:0] air_addr, // Air address
	input wire logic [15:0] slv_rdata, // Serial read word
	input wire logic slv_wr_en, // Serial write allowed
	input wire logic [15:0] err_status, // Error status
	input wire logic air_reply, // Reply strobe
	input wire logic area_unlocked // Area open
);
	logic rd, wr, stat, air_go, perm_hit, pw_zone;
	assign rd = slv_req && slv_op == tmap_pkg::SLAVE_WORD_READ_CMD;
	assign wr = slv_req && slv_op == tmap_pkg::SLAVE_WORD_WRITE_CMD;
	assign stat = slv_req && slv_op == tmap_pkg::SLAVE_STATUS_READ_CMD;
	assign air_go = air_req && air_cmd == tmap_pkg::AIR_WRITE_CMD;
	assign perm_hit = perm_mask[15 - int'(slv_addr[11:9])];
	assign pw_zone = air_bank == tmap_pkg::BANK_RESERVED
		&& air_addr >= tmap_pkg::AREA_PW_FIRST
		&& air_addr <= tmap_pkg::AREA_AUTH_LAST;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	rd_killed_a: assert property (rd && killed |=>
		slv_rdata == 16'h0000 && err_status[0])
		else $error("killed read not refused");
	pw_read_a: assert property (rd && access_pw_set |=>
		slv_rdata == 16'h0000 && err_status[1])
		else $error("read under access password passed");
	rsv_read_a: assert property (rd &&
		slv_bank == tmap_pkg::BANK_RESERVED |=>
		slv_rdata == 16'h0000 && err_status[1])
		else $error("reserved read not refused");
	read_pass_a: assert property (rd && !killed && !access_pw_set &&
		slv_bank == tmap_pkg::BANK_EPC |=>
		slv_rdata == $past(slv_mem_rdata))
		else $error("open read lost data");
	upper_zero_a: assert property (err_status[15:2] == 14'h0000)
		else $error("status upper bits set");
	status_read_a: assert property (stat |=>
		slv_rdata == $past(err_status))
		else $error("status read word wrong");
	status_clear_a: assert property (slv_done && !rd && !wr |=>
		err_status == 16'h0000)
		else $error("status not cleared");
	err_sticky_a: assert property (!slv_done |=>
		(err_status & $past(err_status)) == $past(err_status))
		else $error("status bit dropped");
	no_spurious_a: assert property (!rd && !wr |=>
		(err_status & ~$past(err_status)) == 16'h0000)
		else $error("status bit set without access");
	wr_bank_a: assert property (wr &&
		slv_bank != tmap_pkg::BANK_USER |=> !slv_wr_en && err_status[1])
		else $error("non user write passed");
	wr_range_a: assert property (wr &&
		slv_addr > tmap_pkg::USER_LAST_WORD |=> !slv_wr_en)
		else $error("write past end passed");
	wr_perm_a: assert property (wr && perm_hit &&
		slv_addr <= tmap_pkg::USER_LAST_WORD |=> !slv_wr_en)
		else $error("permalocked area written");
	wr_cause_a: assert property (slv_wr_en |-> $past(wr))
		else $error("write enable without write");
	air_unsec_a: assert property (air_go && !secured && pw_zone |=>
		!air_reply)
		else $error("password op while not secured");
	air_cause_a: assert property (air_reply |-> $past(air_go))
		else $error("reply without command");
	cover property (stat ##1 slv_done);
	cover property (wr ##1 slv_wr_en);
	cover property ($rose(area_unlocked));
endmodule : tmap_top_monitor
bind tmap_top tmap_top_monitor tmap_top_monitor_inst (.clk_sys, .srst,
	.killed, .secured, .access_pw_set, .perm_mask, .slv_req, .slv_op,
	.slv_bank, .slv_addr, .slv_mem_rdata, .slv_done, .air_req, .air_cmd,
	.air_bank, .air_addr, .slv_rdata, .slv_wr_en, .err_status, .air_reply,
	.area_unlocked);
`default_nettype wire

// ### verif/tmap_top_tb.sv
// Directed testbench for the tag memory access protection block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
	err_total++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tmap_top_tb;
	logic clk_sys, srst, killed, secured, access_pw_set, slv_req, slv_done;
	logic air_req, slv_wr_en, air_wr_en, air_reply, area_unlocked;
	logic [9:0] lock_payload;
	logic [15:0] perm_mask, slv_mem_rdata, air_data, air_rn16;
	logic [15:0] slv_rdata, err_status;
	logic [7:0] slv_op, air_cmd;
	logic [1:0] slv_bank, air_bank;
	logic [13:0] slv_addr, air_addr;
	logic [2:0] unlocked_area;
	int err_total, samples_checked;
	// Serial write cases: bank, address, mask, lock bits, expected enable
	logic [1:0] wb [8] = '{2'h1, 2'h2, 2'h0, 2'h3, 2'h3, 2'h3, 2'h3, 2'h3};
	logic [13:0] wa [8] = '{14'h0, 14'h0, 14'h0, 14'h0f00, 14'h0, 14'h0200,
		14'h0200, 14'h0e00};
	logic [15:0] pm [8] = '{16'h0, 16'h0, 16'h0, 16'h0, 16'h8000, 16'h8000,
		16'h0, 16'h0100};
	logic [9:0] lp [8] = '{10'h0, 10'h0, 10'h0, 10'h0, 10'h0, 10'h0, 10'h002,
		10'h0};
	logic we [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
	// Air write cases against the lock pairs
	logic [1:0] ab [6] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h3, 2'h1};
	logic [13:0] aa [6] = '{14'h0, 14'h2, 14'h0, 14'h0, 14'h0, 14'h0};
	logic [9:0] al [6] = '{10'h300, 10'h0c0, 10'h030, 10'h00c, 10'h003, 10'h0};
	logic ae [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};

	tmap_top tmap_top_inst (.clk_sys, .srst, .killed, .secured, .access_pw_set,
		.lock_payload, .perm_mask, .slv_req, .slv_op, .slv_bank, .slv_addr,
		.slv_mem_rdata, .slv_done, .air_req, .air_cmd, .air_bank, .air_addr,
		.air_data, .air_rn16, .slv_rdata, .slv_wr_en, .err_status, .air_wr_en,
		.air_reply, .area_unlocked, .unlocked_area);
	tmap_mem_model tmap_mem_model_inst (.bank(slv_bank), .addr(slv_addr),
		.rdata(slv_mem_rdata));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic slv(input logic [7:0] op, input logic [1:0] b,
		input logic [13:0] a);
		@(negedge clk_sys);
		slv_op = op;
		slv_bank = b;
		slv_addr = a;
		slv_req = 1'b1;
		@(negedge clk_sys);
		slv_req = 1'b0;
	endtask : slv

	task automatic air(input logic [1:0] b, input logic [13:0] a,
		input logic [15:0] pw);
		@(negedge clk_sys);
		air_bank = b;
		air_addr = a;
		air_data = pw ^ air_rn16;
		air_req = 1'b1;
		@(negedge clk_sys);
		air_req = 1'b0;
	endtask : air

	task automatic final_report;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : final_report

	initial begin
		repeat (5000) @(posedge clk_sys);
		err_total++;
		final_report();
	end

	initial begin
		{killed, access_pw_set, slv_req, slv_done, air_req} = '0;
		{lock_payload, perm_mask, slv_op, slv_bank, slv_addr} = '0;
		{air_bank, air_addr, air_data} = '0;
		secured = 1'b1;
		air_cmd = tmap_pkg::AIR_WRITE_CMD;
		air_rn16 = 16'h5a5a;
		srst = 1'b1;
		repeat (16) @(negedge clk_sys);
		srst = 1'b0;
		`CHK("status reset", 16'h0000, err_status)
		`CHK("unlocked reset", 1'b0, area_unlocked)
		slv(tmap_pkg::SLAVE_WORD_READ_CMD, tmap_pkg::BANK_EPC, 14'h0010);
		`CHK("epc read", 16'h4010 ^ 16'ha5a5, slv_rdata)
		slv(tmap_pkg::SLAVE_WORD_READ_CMD, tmap_pkg::BANK_RESERVED, 14'h5);
		`CHK("reserved read", 16'h0000, slv_rdata)
		`CHK("locked flag", 16'h0002, err_status)
		slv(8'h01, tmap_pkg::BANK_USER, 14'h0);
		`CHK("bad opcode", 16'h0002, err_status)
		slv(tmap_pkg::SLAVE_STATUS_READ_CMD, 2'h0, 14'h0);
		`CHK("status word", 16'h0002, slv_rdata)
		slv_done = 1'b1;
		@(negedge clk_sys);
		slv_done = 1'b0;
		`CHK("status done", 16'h0000, err_status)
		killed = 1'b1;
		slv(tmap_pkg::SLAVE_WORD_READ_CMD, tmap_pkg::BANK_USER, 14'h0);
		`CHK("killed read", 16'h0000, slv_rdata)
		`CHK("killed flag", 1'b1, err_status[0])
		`CHK("fixed zero", 14'h0000, err_status[15:2])
		killed = 1'b0;
		srst = 1'b1;
		@(negedge clk_sys);
		srst = 1'b0;
		`CHK("power loss", 16'h0000, err_status)
		for (int i = 0; i < 8; i++) begin
			perm_mask = pm[i];
			lock_payload = lp[i];
			slv(tmap_pkg::SLAVE_WORD_WRITE_CMD, wb[i], wa[i]);
			`CHK("serial write", we[i], slv_wr_en)
		end
		perm_mask = 16'h0;
		for (int i = 0; i < 6; i++) begin
			lock_payload = al[i];
			air(ab[i], aa[i], 16'h0001);
			`CHK("air write", ae[i], air_wr_en)
		end
		lock_payload = 10'h0;
		air(tmap_pkg::BANK_RESERVED, 14'h22, 16'h1234);
		`CHK("pw upper", 1'b1, air_reply)
		air(tmap_pkg::BANK_RESERVED, 14'h23, 16'h5678);
		`CHK("pw lower", 1'b1, air_reply)
		slv(tmap_pkg::SLAVE_WORD_READ_CMD, tmap_pkg::BANK_USER, 14'h0200);
		`CHK("guarded read", 16'h0000, slv_rdata)
		air(tmap_pkg::BANK_RESERVED, 14'h32, 16'h1234);
		`CHK("auth half", 1'b1, air_reply)
		air(tmap_pkg::BANK_RESERVED, 14'h33, 16'h0000);
		`CHK("auth fail", 1'b0, air_reply)
		`CHK("still shut", 1'b0, area_unlocked)
		air(tmap_pkg::BANK_RESERVED, 14'h32, 16'h1234);
		air(tmap_pkg::BANK_RESERVED, 14'h33, 16'h5678);
		`CHK("auth ok", 1'b1, air_reply)
		@(negedge clk_sys);
		`CHK("area open", 1'b1, area_unlocked)
		`CHK("area index", 3'h1, unlocked_area)
		slv(tmap_pkg::SLAVE_WORD_READ_CMD, tmap_pkg::BANK_USER, 14'h0200);
		`CHK("open read", 16'hc200 ^ 16'ha5a5, slv_rdata)
		air(tmap_pkg::BANK_RESERVED, 14'h34, 16'h1111);
		air(tmap_pkg::BANK_RESERVED, 14'h35, 16'h1111);
		@(negedge clk_sys);
		`CHK("one area", 3'h1, unlocked_area)
		air(tmap_pkg::BANK_RESERVED, 14'h32, 16'h0000);
		air(tmap_pkg::BANK_RESERVED, 14'h33, 16'h0000);
		`CHK("zero reply", 1'b1, air_reply)
		@(negedge clk_sys);
		`CHK("back secured", 1'b0, area_unlocked)
		secured = 1'b0;
		air(tmap_pkg::BANK_RESERVED, 14'h24, 16'h7777);
		`CHK("unsecured set", 1'b0, air_reply)
		secured = 1'b1;
		lock_payload = 10'h0c0;
		air(tmap_pkg::BANK_RESERVED, 14'h24, 16'h7777);
		`CHK("locked area pw", 1'b0, air_reply)
		lock_payload = 10'h020;
		air(tmap_pkg::BANK_EPC, 14'h0, 16'h0001);
		`CHK("lock secured", 1'b1, air_wr_en)
		air_cmd = 8'hc5;
		air(tmap_pkg::BANK_EPC, 14'h0, 16'h0001);
		`CHK("other code", 1'b0, air_wr_en)
		air_cmd = tmap_pkg::AIR_WRITE_CMD;
		secured = 1'b0;
		air(tmap_pkg::BANK_EPC, 14'h0, 16'h0001);
		`CHK("lock unsecured", 1'b0, air_wr_en)
		secured = 1'b1;
		access_pw_set = 1'b1;
		slv_done = 1'b1;
		slv(tmap_pkg::SLAVE_WORD_READ_CMD, tmap_pkg::BANK_EPC, 14'h0010);
		slv_done = 1'b0;
		`CHK("pw blocks read", 16'h0000, slv_rdata)
		`CHK("set beats clear", 16'h0002, err_status)
		access_pw_set = 1'b0;
		killed = 1'b1;
		slv(tmap_pkg::SLAVE_WORD_WRITE_CMD, tmap_pkg::BANK_USER, 14'h0400);
		`CHK("killed write", 1'b0, slv_wr_en)
		`CHK("killed write flag", 1'b1, err_status[0])
		killed = 1'b0;
		final_report();
	end
endmodule : tmap_top_tb
`default_nettype wire
